// ===== hw/dac_ctrl_defines.svh
// named offsets, field positions, reset values and widths for the dac control
`ifndef DAC_CTRL_DEFINES_SVH
`define DAC_CTRL_DEFINES_SVH

// sizes
`define CHAN_MAX 8
`define ADDR_W 3
`define MAIN_W 10
`define SUB_W 8
`define WORD_W 16
`define PDATA_W 10
`define BITCNT_W 4
`define BITCNT_LAST 4'hf

// serial word fields
`define S_MAIN_SUB 15
`define S_TGT_LO 14
`define S_TGT_HI 13
`define S_ADDR_TOP 12
`define S_ADDR_MID 11
`define S_ADDR_LOW 10
`define S_REF_HI 9
`define S_REF_LO 8
`define S_SLEEP_N 4
`define S_ZERO 3
`define S_CODING 6
`define S_SHUTDOWN_N 5
`define S_GSLEEP 4
`define S_GZERO 3
`define S_MAIN_HI 9
`define S_MAIN_LO 0
`define S_SUB_HI 9
`define S_SUB_LO 2

// parallel word fields
`define P_REF_HI 9
`define P_REF_LO 8
`define P_MAIN_SUB 7
`define P_CODING 6
`define P_SHUTDOWN_N 5
`define P_GSLEEP 4
`define P_GZERO 3
`define P_SLEEP_N 4
`define P_ZERO 3
`define P_TGT_LO 0
`define P_SUB_HI 9
`define P_SUB_LO 2

// reset values
`define RST_CODING 1'b0
`define RST_SHUTDOWN_N 1'b1
`define RST_GSLEEP 1'b1
`define RST_GZERO 1'b0
`define RST_SLEEP_N 1'b1
`define RST_ZERO 1'b1
`define RST_MAIN_SUB 1'b0

// clear codes
`define MAIN_CLR_OB 10'h000
`define MAIN_CLR_TC 10'h000
`define SUB_CLR_OB 8'h80
`define SUB_CLR_TC 8'h00
`define CODING_OB 1'b1

`endif

// ===== hw/dac_ctrl_pkg.sv
// types shared by the dac control modules
package dac_ctrl_pkg;
  `include "dac_ctrl_defines.svh"

  // bias source selection
  typedef enum logic [1:0] {
    REF_HALF_SUPPLY = 2'b00,
    REF_BANDGAP = 2'b01,
    REF_EXTERNAL = 2'b10,
    REF_UNDEFINED = 2'b11
  } ref_sel_t;

  // kind of decoded register write
  typedef enum logic [1:0] {
    WR_SYSTEM = 2'b00,
    WR_CHANNEL = 2'b01,
    WR_MAIN = 2'b10,
    WR_SUB = 2'b11
  } wr_kind_t;

  typedef logic [`MAIN_W-1:0] main_word_t;
  typedef logic [`SUB_W-1:0] sub_word_t;

  // one channel's control register
  typedef struct packed {
    logic sleep_n;
    logic zero_req;
    ref_sel_t ref_sel;
    logic main_sub;
  } chan_cfg_t;

  // one decoded write from either port
  typedef struct packed {
    logic valid;
    wr_kind_t kind;
    logic [`ADDR_W-1:0] addr;
    logic coding;
    logic shutdown_n;
    logic gsleep;
    logic gzero;
    logic sleep_n;
    logic zero_req;
    ref_sel_t ref_sel;
    logic main_sub;
    logic keep_main_sub;
    main_word_t main_val;
    sub_word_t sub_val;
  } wr_req_t;

  // whole state of the core
  typedef struct packed {
    logic coding;
    logic shutdown_n;
    logic gsleep;
    logic gzero;
    chan_cfg_t [`CHAN_MAX-1:0] cfg;
    main_word_t [`CHAN_MAX-1:0] main_data;
    sub_word_t [`CHAN_MAX-1:0] sub_data;
    main_word_t [`CHAN_MAX-1:0] dac_main;
    sub_word_t [`CHAN_MAX-1:0] dac_sub;
    logic tog_d;
    logic update_n_d;
    logic strobe_n_d;
  } core_state_t;

  // link-side shifter state
  typedef struct packed {
    logic [`BITCNT_W-1:0] cnt;
    logic [`WORD_W-2:0] shift;
  } rx_state_t;
endpackage : dac_ctrl_pkg

// ===== hw/rx_link_if.sv
// carrier for a received serial word from the link domain to the core
`timescale 1ns/1ps
interface rx_link_if;
  import dac_ctrl_pkg::*;
  logic [`WORD_W-1:0] word; // last complete word, stable between toggles
  logic word_toggle; // flips once per complete word
  modport src (output word, output word_toggle);
  modport dst (input word, input word_toggle);
endinterface : rx_link_if

// ===== hw/sync_bits.sv
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // levels in and out
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg; // first stage, read only by the second

  // two flops in series
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d_async;
      q <= meta_reg;
    end
  end
endmodule : sync_bits

// ===== hw/serial_rx.sv
// serial shifter on the link clock, hands whole words to the core
`timescale 1ns/1ps
module serial_rx
  import dac_ctrl_pkg::*;
(
  // link pins
  input wire logic serial_clock,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  // reset
  input wire logic resetn,
  // word out
  rx_link_if.src link
);
  rx_state_t rx_reg; // bit counter and shifter
  rx_state_t rx_next;
  logic frame_clear; // end of frame or reset drops partial words
  logic [`WORD_W-1:0] word_reg;
  logic tog_reg;

  assign frame_clear = !resetn || frame_sync_n;
  assign link.word = word_reg;
  assign link.word_toggle = tog_reg;

  // shift msb first, counter wraps after the 16th bit
  always_comb begin
    rx_next = rx_reg;
    rx_next.shift = {rx_reg.shift[`WORD_W-3:0], serial_data_in};
    rx_next.cnt = rx_reg.cnt + 4'h1;
  end

  // partial frames are wiped by frame sync going high
  always_ff @(negedge serial_clock or posedge frame_clear) begin
    if (frame_clear) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // commit only a full 16-bit word, then flip the toggle
  always_ff @(negedge serial_clock or negedge resetn) begin
    if (!resetn) begin
      word_reg <= '0;
      tog_reg <= 1'b0;
    end else if (!frame_sync_n && rx_reg.cnt == `BITCNT_LAST) begin
      word_reg <= {rx_reg.shift, serial_data_in};
      tog_reg <= !tog_reg;
    end
  end
endmodule : serial_rx

// ===== hw/dac_ctrl_top.sv
// register and control core of a quad/octal 10-bit dac
// Functional notes
// - octal decodes three address bits, quad two
// - channel sleep bit low puts channel asleep
// - channel clear zeroes main data, sub untouched
// - clear code depends on coding selection; main clear code is 000 in both codings
// - two bits choose channel bias source
// - serial top bit picks sub or main
// - sub register eight bits, two lsbs dropped
// - sub coding follows global coding
// - power-up: shutdown bit 1, global sleep 1
// - power-up channel: sleep 1, clear 1, ref 0
// - words 0060 and 0020 set coding, wake
// - word 4110 wakes channel a on bandgap
// - main write: address then ten data bits
// - dac codes change only on update strobe or hardware clear
// - mode pin picks data or control registers
// - hardware clear resets main and sub data
// - serial shifts msb first on falling clock
// - update strobe low loads all channels together
// - coding bit 0 twos complement, 1 offset
`timescale 1ns/1ps
module dac_ctrl_top
  import dac_ctrl_pkg::*;
#(
  parameter bit OCTAL = 1'b1 // 1 eight channels, 0 four channels
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // serial link
  input wire logic serial_clock,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  // parallel port
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic mode,
  input wire logic chan_addr_bit2,
  input wire logic chan_addr_bit1,
  input wire logic chan_addr_bit0,
  input wire logic [`PDATA_W-1:0] par_data,
  // asynchronous control pins
  input wire logic output_update_strobe_n,
  input wire logic hw_clear_n,
  // global state out
  output logic coding_select,
  output logic full_shutdown_n,
  output logic global_sleep,
  output logic global_zero_request,
  // per channel state out
  output logic [`CHAN_MAX-1:0] channel_sleep_n,
  output logic [`CHAN_MAX-1:0] ref_select_hi,
  output logic [`CHAN_MAX-1:0] ref_select_lo,
  output main_word_t [`CHAN_MAX-1:0] dac_main_code,
  output sub_word_t [`CHAN_MAX-1:0] dac_sub_code
);
  // width of the synchroniser bundle: word toggle, update strobe, hardware
  // clear, write strobe and mode pin, then the address and data pins; the
  // reset value keeps every strobe at its idle level so that no false edge
  // is seen in the first cycles after reset is released
  localparam int SYNC_W = 5 + `ADDR_W + `PDATA_W;
  localparam logic [SYNC_W-1:0] SYNC_RST = {2'b01, 1'b1, 1'b1, 1'b0,
    {`ADDR_W{1'b0}}, {`PDATA_W{1'b0}}};

  core_state_t st_reg; // registered state
  core_state_t st_next; // next state
  rx_link_if rx_link (); // serial word carrier
  logic strobe_n_raw; // parallel write strobe, active low
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic tog_s; // synchronised word toggle
  logic update_n_s; // synchronised update strobe
  logic clear_n_s; // synchronised hardware clear
  logic strobe_n_s; // synchronised parallel strobe
  logic mode_s; // synchronised mode pin
  logic [`ADDR_W-1:0] addr_s; // synchronised address pins
  logic [`PDATA_W-1:0] pdata_s; // synchronised parallel data
  wr_req_t ser_req; // decoded serial write
  wr_req_t par_req; // decoded parallel write

  // the shifter lives entirely in the link clock domain; only the word
  // toggle crosses through flops, the word itself is held stable from one
  // toggle to the next so the core may read it without its own sampling
  // serial shifter on the link clock
  serial_rx u_serial_rx (
    .serial_clock(serial_clock),
    .frame_sync_n(frame_sync_n),
    .serial_data_in(serial_data_in),
    .resetn(resetn),
    .link(rx_link.src)
  );

  // the two strobes are merged before synchronising, so a skew between
  // select and write at the pins can never look like two separate writes;
  // the host keeps address and data steady until the merged strobe is seen
  // a write is taken at the end of the time select and write are both low
  assign strobe_n_raw = chip_select_n || write_n;
  assign sync_in = {rx_link.word_toggle, output_update_strobe_n, hw_clear_n,
    strobe_n_raw, mode, chan_addr_bit2, chan_addr_bit1, chan_addr_bit0,
    par_data};

  // address and data pass the same two stages as the strobe, so they are
  // always at least as settled as the strobe edge that commits them;
  // the update strobe and hardware clear share the same path
  // every parallel-port and control pin passes two flops
  sync_bits #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d_async(sync_in),
    .q(sync_out)
  );

  assign {tog_s, update_n_s, clear_n_s, strobe_n_s, mode_s, addr_s,
    pdata_s} = sync_out;

  // address decode, quad ignores the top bit
  function automatic logic [`ADDR_W-1:0] chan_of(
    input logic top, input logic mid, input logic low);
    chan_of = {top & OCTAL, mid, low};
  endfunction : chan_of

  // main clear code for the selected coding
  function automatic main_word_t main_clear(input logic coding);
    main_clear = (coding == `CODING_OB) ? `MAIN_CLR_OB : `MAIN_CLR_TC;
  endfunction : main_clear

  // sub midscale code for the selected coding, zero contribution
  function automatic sub_word_t sub_clear(input logic coding);
    sub_clear = (coding == `CODING_OB) ? `SUB_CLR_OB : `SUB_CLR_TC;
  endfunction : sub_clear

  // a serial word is acted on once, in the cycle in which the synchronised
  // toggle differs from its registered copy; all fields are decoded every
  // cycle and only the valid flag decides whether anything is written
  // decode a received serial word
  always_comb begin
    logic [`WORD_W-1:0] w;
    w = rx_link.word;
    ser_req = '0;
    ser_req.valid = (tog_s != st_reg.tog_d);
    ser_req.addr = chan_of(w[`S_ADDR_TOP], w[`S_ADDR_MID], w[`S_ADDR_LOW]);
    ser_req.keep_main_sub = 1'b1;
    // bit 13 high means data, else bit 14 picks channel or system
    if (w[`S_TGT_HI]) begin
      ser_req.kind = w[`S_MAIN_SUB] ? WR_SUB : WR_MAIN;
    end else if (w[`S_TGT_LO]) begin
      ser_req.kind = WR_CHANNEL;
    end else begin
      ser_req.kind = WR_SYSTEM;
    end
    ser_req.coding = w[`S_CODING];
    ser_req.shutdown_n = w[`S_SHUTDOWN_N];
    ser_req.gsleep = w[`S_GSLEEP];
    ser_req.gzero = w[`S_GZERO];
    ser_req.sleep_n = w[`S_SLEEP_N];
    ser_req.zero_req = w[`S_ZERO];
    ser_req.ref_sel = ref_sel_t'({w[`S_REF_HI], w[`S_REF_LO]});
    ser_req.main_val = w[`S_MAIN_HI:`S_MAIN_LO];
    ser_req.sub_val = w[`S_SUB_HI:`S_SUB_LO];
  end

  // parallel writes commit on the rising end of the strobe; by then the
  // data pins have had the whole low phase to settle through the flops,
  // and the stored main/sub bit of the channel steers a data write
  // decode a parallel write at the end of its strobe
  always_comb begin
    par_req = '0;
    par_req.valid = strobe_n_s && !st_reg.strobe_n_d;
    par_req.addr = addr_s;
    par_req.addr[`ADDR_W-1] = addr_s[`ADDR_W-1] & OCTAL;
    par_req.keep_main_sub = 1'b0;
    // mode high goes to data, low to control registers
    if (mode_s) begin
      // the stored main/sub bit steers the data write
      par_req.kind = st_reg.cfg[par_req.addr].main_sub ? WR_SUB
        : WR_MAIN;
    end else if (pdata_s[`P_TGT_LO]) begin
      par_req.kind = WR_CHANNEL;
    end else begin
      par_req.kind = WR_SYSTEM;
    end
    par_req.coding = pdata_s[`P_CODING];
    par_req.shutdown_n = pdata_s[`P_SHUTDOWN_N];
    par_req.gsleep = pdata_s[`P_GSLEEP];
    par_req.gzero = pdata_s[`P_GZERO];
    par_req.sleep_n = pdata_s[`P_SLEEP_N];
    par_req.zero_req = pdata_s[`P_ZERO];
    par_req.ref_sel = ref_sel_t'({pdata_s[`P_REF_HI], pdata_s[`P_REF_LO]});
    par_req.main_sub = pdata_s[`P_MAIN_SUB];
    par_req.main_val = pdata_s;
    par_req.sub_val = pdata_s[`P_SUB_HI:`P_SUB_LO];
  end

  // one function serves both ports so that serial and parallel writes
  // have the same effect, except that only a parallel channel write sets the main/sub bit; a write with the valid
  // flag low returns the state unchanged
  // apply one decoded write to a state copy
  function automatic core_state_t apply_write(
    input core_state_t s, input wr_req_t r);
    core_state_t o;
    o = s;
    if (r.valid) begin
      unique case (r.kind)
        // global controls, address ignored
        WR_SYSTEM: begin
          o.coding = r.coding;
          o.shutdown_n = r.shutdown_n;
          o.gsleep = r.gsleep;
          o.gzero = r.gzero;
        end
        // only the addressed channel changes
        WR_CHANNEL: begin
          o.cfg[r.addr].sleep_n = r.sleep_n;
          o.cfg[r.addr].zero_req = r.zero_req;
          o.cfg[r.addr].ref_sel = r.ref_sel;
          if (!r.keep_main_sub) begin
            o.cfg[r.addr].main_sub = r.main_sub;
          end
          // clear hits the main data only, sub stays
          if (r.zero_req) begin
            o.main_data[r.addr] = main_clear(s.coding);
          end
        end
        // main data is held at clear while a clear is set
        WR_MAIN: begin
          if (!s.cfg[r.addr].zero_req && !s.gzero) begin
            o.main_data[r.addr] = r.main_val;
          end
        end
        // sub data, eight bits
        WR_SUB: begin
          o.sub_data[r.addr] = r.sub_val;
        end
      endcase
    end
    apply_write = o;
  endfunction : apply_write

  // the order below sets the priority: port writes first, then the global
  // clear, then the update strobe, and last the hardware clear, which wins
  // over everything else on the data and dac registers; the update strobe
  // is edge detected so a long low pulse loads the outputs only once
  // next state: writes, global clear, output update, then hardware clear
  always_comb begin
    st_next = st_reg;
    st_next.tog_d = tog_s;
    st_next.update_n_d = update_n_s;
    st_next.strobe_n_d = strobe_n_s;
    // serial first, a parallel write in the same cycle lands on top
    st_next = apply_write(st_next, ser_req);
    st_next = apply_write(st_next, par_req);
    // global clear holds all main data at the clear code
    if (st_next.gzero) begin
      for (int i = 0; i < `CHAN_MAX; i++) begin
        st_next.main_data[i] = main_clear(st_next.coding);
      end
    end
    // update strobe falling loads every channel together
    if (!update_n_s && st_reg.update_n_d) begin
      for (int i = 0; i < `CHAN_MAX; i++) begin
        // a channel with clear set loads the clear code
        if (st_next.cfg[i].zero_req || st_next.gzero) begin
          st_next.dac_main[i] = main_clear(st_next.coding);
        end else begin
          st_next.dac_main[i] = st_next.main_data[i];
        end
        st_next.dac_sub[i] = st_next.sub_data[i];
      end
    end
    // hardware clear overrides everything on data and dac registers
    if (!clear_n_s) begin
      for (int i = 0; i < `CHAN_MAX; i++) begin
        st_next.main_data[i] = main_clear(st_next.coding);
        st_next.dac_main[i] = main_clear(st_next.coding);
        st_next.sub_data[i] = sub_clear(st_next.coding);
        st_next.dac_sub[i] = sub_clear(st_next.coding);
      end
    end
  end

  // power-up leaves the device in global sleep with every channel clear
  // set, so no main code output can move until the host has configured the part;
  // the edge detector copies reset to the idle level of their strobes
  // state register with power-up defaults
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg.coding <= `RST_CODING;
      st_reg.shutdown_n <= `RST_SHUTDOWN_N;
      st_reg.gsleep <= `RST_GSLEEP;
      st_reg.gzero <= `RST_GZERO;
      for (int i = 0; i < `CHAN_MAX; i++) begin
        st_reg.cfg[i].sleep_n <= `RST_SLEEP_N;
        st_reg.cfg[i].zero_req <= `RST_ZERO;
        st_reg.cfg[i].ref_sel <= REF_HALF_SUPPLY;
        st_reg.cfg[i].main_sub <= `RST_MAIN_SUB;
        st_reg.main_data[i] <= `MAIN_CLR_TC;
        st_reg.dac_main[i] <= `MAIN_CLR_TC;
        st_reg.sub_data[i] <= `SUB_CLR_TC;
        st_reg.dac_sub[i] <= `SUB_CLR_TC;
      end
      st_reg.tog_d <= 1'b0;
      st_reg.update_n_d <= 1'b1;
      st_reg.strobe_n_d <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output below is a plain wire from the state register, so the
  // pins never show a combinational glitch while a write is decoded;
  // the dac codes change only in the cycle after an update or clear
  // outputs straight from the state register
  assign coding_select = st_reg.coding;
  assign full_shutdown_n = st_reg.shutdown_n;
  assign global_sleep = st_reg.gsleep;
  assign global_zero_request = st_reg.gzero;
  assign dac_main_code = st_reg.dac_main;
  assign dac_sub_code = st_reg.dac_sub;

  // the channel fields are spread into one vector per bit so each pin
  // group carries a single control across all channels
  // per channel control bits out
  always_comb begin
    for (int i = 0; i < `CHAN_MAX; i++) begin
      channel_sleep_n[i] = st_reg.cfg[i].sleep_n;
      ref_select_hi[i] = st_reg.cfg[i].ref_sel[1];
      ref_select_lo[i] = st_reg.cfg[i].ref_sel[0];
    end
  end
endmodule : dac_ctrl_top

// ===== sim/dac_ctrl_top_sva.sv
// concurrent checks on the dac control top ports
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"
module dac_ctrl_chk
  import dac_ctrl_pkg::*;
#(
  parameter bit OCTAL = 1'b1 // channel count of the watched core
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // watched inputs
  input wire logic frame_sync_n,
  input wire logic chip_select_n,
  input wire logic output_update_strobe_n,
  input wire logic hw_clear_n,
  // watched outputs
  input wire logic coding_select,
  input wire logic full_shutdown_n,
  input wire logic global_sleep,
  input wire logic global_zero_request,
  input wire logic [`CHAN_MAX-1:0] channel_sleep_n,
  input wire logic [`CHAN_MAX-1:0] ref_select_hi,
  input wire logic [`CHAN_MAX-1:0] ref_select_lo,
  input wire main_word_t [`CHAN_MAX-1:0] dac_main_code,
  input wire sub_word_t [`CHAN_MAX-1:0] dac_sub_code
);
  logic [3:0] wr_idle; // cycles since a host write was in flight
  logic [3:0] ld_idle; // cycles since update or clear was low
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // saturating idle counters, cleared by activity
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_idle <= 4'hf;
      ld_idle <= 4'hf;
    end else begin
      wr_idle <= (!frame_sync_n || !chip_select_n) ? 4'h0 :
        wr_idle + {3'h0, wr_idle != 4'hf};
      ld_idle <= (!output_update_strobe_n || !hw_clear_n) ? 4'h0 :
        ld_idle + {3'h0, ld_idle != 4'hf};
    end
  end
  reset_vals_a: assert property (
    $rose(resetn) |-> full_shutdown_n && global_sleep &&
    channel_sleep_n == '1 && {ref_select_hi, ref_select_lo} == '0)
    else $error("reset values wrong");
  dac_hold_a: assert property (
    $changed({dac_main_code, dac_sub_code}) |-> ld_idle < 4'h8)
    else $error("dac code moved without update");
  cfg_hold_a: assert property (
    $changed({coding_select, full_shutdown_n, global_sleep,
    global_zero_request, channel_sleep_n, ref_select_hi,
    ref_select_lo}) |-> wr_idle < 4'h8)
    else $error("control moved without write");
  sleep_one_a: assert property (
    $changed(channel_sleep_n) |->
    $onehot(channel_sleep_n ^ $past(channel_sleep_n)))
    else $error("sleep moved on several channels");
  ref_one_a: assert property (
    $changed(ref_select_lo) |->
    $onehot(ref_select_lo ^ $past(ref_select_lo)))
    else $error("ref moved on several channels");
  hw_main_a: assert property (
    !hw_clear_n [*8] |-> dac_main_code == '0)
    else $error("hw clear left main code");
  hw_sub_a: assert property (
    !hw_clear_n [*8] |->
    dac_sub_code == (coding_select ? {`CHAN_MAX{8'h80}} : '0))
    else $error("hw clear left sub code");
  gzero_a: assert property (
    (global_zero_request && !output_update_strobe_n) [*8] |->
    dac_main_code == '0)
    else $error("global clear not loaded");
endmodule : dac_ctrl_chk
bind dac_ctrl_top dac_ctrl_chk #(.OCTAL(OCTAL)) i_dac_ctrl_chk (
  .clk_sys, .resetn, .frame_sync_n, .chip_select_n,
  .output_update_strobe_n, .hw_clear_n, .coding_select,
  .full_shutdown_n, .global_sleep, .global_zero_request,
  .channel_sleep_n, .ref_select_hi, .ref_select_lo, .dac_main_code,
  .dac_sub_code);

// ===== sim/host_link.sv
// host model that drives whole or cut frames onto the serial link
`timescale 1ns/1ps
module host_link (
  // link pins driven by the host
  output logic serial_clock,
  output logic frame_sync_n,
  output logic serial_data_in
);
  // link idles with clock high and frame closed
  initial begin
    serial_clock = 1'b1;
    frame_sync_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // send the top nbits of w msb first, then close the frame
  task automatic send(input logic [15:0] w, input int nbits);
    frame_sync_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      serial_data_in = w[i];
      #80 serial_clock = 1'b0; // device samples here
      #80 serial_clock = 1'b1;
    end
    #80 frame_sync_n = 1'b1;
    serial_data_in = ~serial_data_in; // released line shows no stale bit
    #320;
  endtask : send
endmodule : host_link

// ===== sim/tb_dac_ctrl_top.sv
// self-checking bench for the dac control top
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"
module tb_dac_ctrl_top;
  import dac_ctrl_pkg::*;
  logic clk_sys = 1'b0; // core clock
  logic resetn = 1'b0; // core reset
  logic serial_clock, frame_sync_n, serial_data_in; // link pins
  logic chip_select_n = 1'b1, write_n = 1'b1, mode = 1'b0; // port
  logic [2:0] addr = 3'h0; // channel address pins
  logic [`PDATA_W-1:0] par_data = '0; // parallel data
  logic output_update_strobe_n = 1'b1, hw_clear_n = 1'b1; // async
  logic coding_select, full_shutdown_n, global_sleep, global_zero_request;
  logic [`CHAN_MAX-1:0] channel_sleep_n, ref_select_hi, ref_select_lo;
  main_word_t [`CHAN_MAX-1:0] dac_main_code; // output main codes
  sub_word_t [`CHAN_MAX-1:0] dac_sub_code; // output sub codes
  int n_fail = 0, compares = 0; // result counters
  // 25 mhz core clock
  always #20 clk_sys = ~clk_sys;
  host_link i_host_link (.serial_clock, .frame_sync_n, .serial_data_in);
  dac_ctrl_top i_dac_ctrl_top (.clk_sys, .resetn, .serial_clock,
    .frame_sync_n, .serial_data_in, .chip_select_n, .write_n, .mode,
    .chan_addr_bit2(addr[2]), .chan_addr_bit1(addr[1]),
    .chan_addr_bit0(addr[0]), .par_data, .output_update_strobe_n,
    .hw_clear_n, .coding_select, .full_shutdown_n, .global_sleep,
    .global_zero_request, .channel_sleep_n, .ref_select_hi,
    .ref_select_lo, .dac_main_code, .dac_sub_code);
  // wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // one serial frame, then time for the core to commit it
  task automatic ser(input logic [15:0] w, input int nbits = 16);
    i_host_link.send(w, nbits);
    cyc(8);
  endtask : ser
  // one parallel write with select and write held low
  task automatic par(input logic m, input logic [2:0] a,
    input logic [9:0] d);
    {mode, addr, par_data} = {m, a, d};
    chip_select_n = 1'b0;
    write_n = 1'b0;
    cyc(4);
    chip_select_n = 1'b1;
    write_n = 1'b1;
    cyc(8);
  endtask : par
  // low pulse on the update strobe or the hardware clear
  task automatic pulse(input bit hw);
    if (hw) hw_clear_n = 1'b0;
    else output_update_strobe_n = 1'b0;
    cyc(10);
    {hw_clear_n, output_update_strobe_n} = 2'b11;
    cyc(4);
  endtask : pulse
  task automatic fail(input string m);
    n_fail++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task automatic chk1(input logic g, input logic e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask : chk1
  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
    input string m);
    compares++;
    if (g !== e) fail(m);
  endtask : chk8
  task automatic chkm(input int c, input main_word_t e);
    compares++;
    if (dac_main_code[c] !== e) fail($sformatf("main code %0d", c));
  endtask : chkm
  task automatic chks(input int c, input sub_word_t e);
    compares++;
    if (dac_sub_code[c] !== e) fail($sformatf("sub code %0d", c));
  endtask : chks
  // verdict and end of run
  task automatic end_sim();
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // watchdog cuts a hang short
  initial begin
    #2000000;
    fail("watchdog expired");
    end_sim();
  end
  // main sequence
  initial begin
    cyc(8);
    resetn = 1'b1;
    cyc(4);
    chk1(coding_select, 1'b0, "coding");
    chk1(global_sleep, 1'b1, "global sleep");
    chk8(channel_sleep_n, 8'hff, "sleep");
    chkm(0, 10'h000);
    $display("test reset done");
    ser(16'h0020);
    chk1(global_sleep, 1'b0, "global sleep");
    chk1(full_shutdown_n, 1'b1, "shutdown");
    ser(16'h0060);
    chk1(coding_select, 1'b1, "coding");
    ser(16'h2200);
    pulse(0);
    chkm(0, 10'h000);
    $display("test system done");
    ser(16'h4110);
    chk8(ref_select_lo, 8'h01, "ref lo");
    for (int c = 1; c < 8; c++) begin
      ser(16'h4000 | 16'(c << 10) | 16'((c % 3) << 8) |
        (c == 7 ? 16'h0 : 16'h10));
    end
    chk8(channel_sleep_n, 8'h7f, "sleep");
    chk8(ref_select_lo, 8'h93, "ref lo");
    chk8(ref_select_hi, 8'h24, "ref hi");
    $display("test channel done");
    ser(16'h2200);
    ser(16'ha200);
    ser(16'h3d55);
    chkm(0, 10'h000);
    pulse(0);
    chkm(0, 10'h200);
    chks(0, 8'h80);
    chkm(7, 10'h155);
    ser(16'ha1ff);
    pulse(0);
    chks(0, 8'h7f);
    chkm(0, 10'h200);
    ser(16'h23ff, 10);
    pulse(0);
    chkm(0, 10'h200);
    $display("test data done");
    ser(16'h4118);
    chkm(0, 10'h200);
    pulse(0);
    chkm(0, 10'h000);
    chks(0, 8'h7f);
    $display("test channel clear done");
    par(1'b0, 3'h0, 10'h020);
    chk1(coding_select, 1'b0, "coding");
    par(1'b0, 3'h5, 10'h191);
    par(1'b1, 3'h5, 10'h2a8);
    par(1'b0, 3'h5, 10'h111);
    par(1'b1, 3'h5, 10'h1c3);
    chk1(ref_select_lo[5], 1'b1, "ref lo");
    pulse(0);
    chkm(5, 10'h1c3);
    chks(5, 8'haa);
    $display("test parallel done");
    pulse(1);
    chkm(0, 10'h000);
    chks(5, 8'h00);
    ser(16'h0060);
    pulse(1);
    chks(1, 8'h80);
    $display("test hardware clear done");
    ser(16'h0048);
    chk1(full_shutdown_n, 1'b0, "shutdown");
    chk1(global_zero_request, 1'b1, "global clear");
    ser(16'h4110);
    ser(16'h2111);
    pulse(0);
    chkm(0, 10'h000);
    $display("test global clear done");
    end_sim();
  end
endmodule : tb_dac_ctrl_top
